// ---- dv/cpu_status_flags_and_bank_pointer_tb.sv ----
// self-checking testbench of the status flags, bank pointer and table read block
`timescale 1ns/1ps
module cpu_status_flags_and_bank_pointer_tb;
  logic CLK_SYS = 1'b0;
  logic RST_N = 1'b0;
  logic PSEL = 1'b0;
  logic PENABLE = 1'b0;
  logic PWRITE = 1'b0;
  logic [7:0] PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h0;
  logic [31:0] PRDATA;
  logic PREADY, PSLVERR, PC_LOAD, PIPE_STALL, IND_ACTIVE;
  logic [15:0] TABLE_WORD, TABLE_ADDR;
  logic [1:0] BRANCH_BANK;
  logic [7:0] PC_LOW;
  logic [9:0] DATA_ADDR;
  logic [7:0] exp_f = 8'h00;
  logic [7:0] kn = 8'h30;
  logic last_err;
  int bad_count = 0;
  int compares = 0;
  int cyc = 0;
  ////////////////////////////////////////////////////////////////////////////////
  csf_core i_csf_core (.CLK_SYS(CLK_SYS), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .TABLE_WORD(TABLE_WORD), .TABLE_ADDR(TABLE_ADDR),
    .BRANCH_BANK(BRANCH_BANK), .PC_LOW(PC_LOW), .PC_LOAD(PC_LOAD), .PIPE_STALL(PIPE_STALL),
    .DATA_ADDR(DATA_ADDR), .IND_ACTIVE(IND_ACTIVE));
  csf_prog_mem i_csf_prog_mem (.addr(TABLE_ADDR), .word(TABLE_WORD));
  initial forever #25 CLK_SYS = ~CLK_SYS;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic test_done;
    $display("counts: compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // a hang in any wait is cut short here
  always @(posedge CLK_SYS) begin
    cyc++;
    if (cyc == 30000) begin
      bad_count++;
      test_done;
    end
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] wd,
                     output logic [31:0] rdat);
    @(posedge CLK_SYS);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= ad;
    PWDATA <= wd;
    @(posedge CLK_SYS);
    PENABLE <= 1'b1;
    @(posedge CLK_SYS);
    while (PREADY !== 1'b1) begin
      @(posedge CLK_SYS);
    end
    rdat = PRDATA;
    last_err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    logic [31:0] t;
    apb(1'b1, ad, d, t);
  endtask
  task automatic rd(input logic [7:0] ad, output logic [31:0] d);
    apb(1'b0, ad, 32'h0, d);
  endtask
  task automatic sys_step(input logic [7:0] ad, input logic [7:0] d, input logic [7:0] e);
    logic [31:0] v;
    wr(ad, {24'h0, d});
    rd(csf_pkg::OFF_FLAGS, v);
    chk("wdt_sleep", v & 32'h30, {24'h0, e});
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // returns {flags, result}; subtract adds the inverted operand, carry means no borrow
  function automatic logic [15:0] alu_m(input logic [2:0] op, input logic [7:0] a, b, f);
    logic [7:0] bb, r, g, l7;
    logic [8:0] s;
    logic [4:0] h;
    logic ci;
    bb = op[1] ? ~b : b;
    ci = op[0] ? f[0] : op[1];
    s = {1'b0, a} + {1'b0, bb} + {8'h00, ci};
    h = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, ci};
    l7 = {1'b0, a[6:0]} + {1'b0, bb[6:0]} + {7'h00, ci};
    g = f;
    r = s[7:0];
    case (op)
      3'h4: r = a & b;
      3'h7: r = a ^ b;
      3'h5: begin
        r = {a[6:0], f[0]};
        g[0] = a[7];
      end
      3'h6: begin
        r = {f[0], a[7:1]};
        g[0] = a[0];
      end
      default: begin
        g[0] = s[8];
        g[1] = h[4];
        g[3] = l7[7] ^ s[8];
        g[7] = g[3] ^ r[7];
      end
    endcase
    g[2] = (r == 8'h00);
    if (op == 3'h2) g[6] = g[2];
    if (op == 3'h3) g[6] = f[6] & g[2];
    return {g, r};
  endfunction
  task automatic do_op(input logic [2:0] op, input logic [7:0] a, b, input logic [3:0] f);
    logic [15:0] m;
    logic [31:0] v;
    wr(csf_pkg::OFF_ACC, {24'h0, a});
    // random upper nibble: software must not reach the read-only flags
    wr(csf_pkg::OFF_FLAGS, {24'h0, 4'($urandom), f});
    exp_f[3:0] = f;
    kn[3:0] = 4'hF;
    wr(csf_pkg::OFF_OP, {21'h0, op, b});
    m = alu_m(op, a, b, exp_f);
    exp_f = m[15:8];
    if (!op[2]) kn[7] = 1'b1;
    if (op == 3'h2) kn[6] = 1'b1;
    rd(csf_pkg::OFF_ACC, v);
    chk("acc", v, {24'h0, m[7:0]});
    rd(csf_pkg::OFF_FLAGS, v);
    chk("flags", v & {24'h0, kn}, {24'h0, exp_f & kn});
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] v;
    logic [7:0] x, y;
    logic [1:0] s;
    void'($urandom(48606));
    repeat (10) @(posedge CLK_SYS);
    RST_N <= 1'b1;
    rd(csf_pkg::OFF_BANK, v);
    chk("bank_rst", v, 32'h0);
    rd(csf_pkg::OFF_FLAGS, v);
    chk("wdt_sleep_rst", v & 32'h30, 32'h0);
    for (int i = 0; i < 4; i++) begin
      wr(csf_pkg::OFF_BANK, 32'(8'hFC | i));
      rd(csf_pkg::OFF_BANK, v);
      chk("bank", v, 32'(i));
      wr(csf_pkg::OFF_SYS, 32'h10);
      #1 chk("branch_bank", {30'h0, BRANCH_BANK}, 32'(i));
    end
    $display("test bank done");
    sys_step(csf_pkg::OFF_SYS, 8'h01, 8'h20);
    sys_step(csf_pkg::OFF_FLAGS, 8'hFF, 8'h20);
    sys_step(csf_pkg::OFF_SYS, 8'h04, 8'h10);
    sys_step(csf_pkg::OFF_SYS, 8'h03, 8'h20);
    sys_step(csf_pkg::OFF_SYS, 8'h06, 8'h10);
    sys_step(csf_pkg::OFF_SYS, 8'h02, 8'h00);
    $display("test system flags done");
    x = 8'($urandom);
    wr(csf_pkg::OFF_PCLOW, {24'h0, x});
    #1 chk("pc_low", {24'h0, PC_LOW}, {24'h0, x});
    chk("pc_load", {31'h0, PC_LOAD}, 32'h1);
    chk("stall", {31'h0, PIPE_STALL}, 32'h1);
    @(posedge CLK_SYS);
    #1 chk("pc_load_end", {31'h0, PC_LOAD}, 32'h0);
    chk("stall_dummy", {31'h0, PIPE_STALL}, 32'h1);
    @(posedge CLK_SYS);
    #1 chk("stall_end", {31'h0, PIPE_STALL}, 32'h0);
    $display("test pc low done");
    repeat (3) begin
      x = 8'($urandom);
      y = 8'($urandom);
      wr(csf_pkg::OFF_TBL_LOW, {24'h0, x});
      wr(csf_pkg::OFF_TBL_HIGH, {24'h0, y});
      #1 chk("tbl_addr", {16'h0, TABLE_ADDR}, {16'h0, y, x});
      wr(csf_pkg::OFF_SYS, 32'h08);
      rd(csf_pkg::OFF_TBL_HBYTE, v);
      chk("tbl_high", v, {24'h0, x ^ 8'h5A});
      rd(csf_pkg::OFF_ACC, v);
      chk("tbl_low", v, {24'h0, y + 8'h3C});
    end
    $display("test table read done");
    x = 8'($urandom);
    y = 8'($urandom);
    s = 2'($urandom);
    wr(csf_pkg::OFF_ACC, {24'h0, x});
    wr(csf_pkg::OFF_PTR0, {24'h0, ~x});
    wr(csf_pkg::OFF_IND0, 32'h55);
    #1 chk("ind0_addr", {22'h0, DATA_ADDR}, {24'h0, x});
    chk("ind_active", {31'h0, IND_ACTIVE}, 32'h1);
    rd(csf_pkg::OFF_IND0, v);
    chk("ind0_read", v, 32'h0);
    wr(csf_pkg::OFF_ACC, {24'h0, y});
    wr(csf_pkg::OFF_WPTR_LOW, 32'h0);
    wr(csf_pkg::OFF_ACC, {30'h0, s});
    wr(csf_pkg::OFF_WPTR_SEC, 32'h0);
    wr(csf_pkg::OFF_IND1, 32'hAA);
    #1 chk("ind1_addr", {22'h0, DATA_ADDR}, {22'h0, s, y});
    rd(csf_pkg::OFF_IND1, v);
    chk("ind1_read", v, 32'h0);
    wr(csf_pkg::OFF_ACC, {24'h0, x});
    wr(csf_pkg::OFF_DADDR, {30'h0, ~s});
    #1 chk("direct_addr", {22'h0, DATA_ADDR}, {22'h0, ~s, x});
    chk("ind_idle", {31'h0, IND_ACTIVE}, 32'h0);
    rd(8'h40, v);
    chk("unmapped", {v[30:0], last_err}, 32'h0);
    $display("test addressing done");
    do_op(3'h0, 8'h7F, 8'h01, 4'h0);
    do_op(3'h2, 8'h00, 8'h00, 4'h0);
    do_op(3'h3, 8'h00, 8'h00, 4'h1);
    do_op(3'h3, 8'h05, 8'h04, 4'h1);
    do_op(3'h2, 8'h80, 8'h01, 4'h0);
    do_op(3'h1, 8'hFF, 8'h00, 4'h1);
    do_op(3'h5, 8'h80, 8'h00, 4'h1);
    do_op(3'h6, 8'h01, 8'h00, 4'h0);
    for (int i = 0; i < 400; i++) begin
      do_op(3'($urandom), 8'($urandom), 8'($urandom), 4'($urandom));
    end
    $display("test alu flags done");
    test_done;
  end
endmodule

// ---- dv/csf_prog_mem.sv ----
// program memory model that answers table fetches from the core
`timescale 1ns/1ps
module csf_prog_mem (
  input wire logic [15:0] addr,
  output logic [15:0] word
);
  // both address bytes shape the word, so swapped or stale pointers show up
  assign word = {addr[7:0] ^ 8'h5A, addr[15:8] + 8'h3C};
endmodule

// ---- verilog/csf_alu.sv ----
// flag-generating 8-bit arithmetic and logic unit
`timescale 1ns/1ps
module csf_alu (
  input wire logic [7:0] a,
  input wire logic [7:0] b,
  input wire logic [2:0] op,
  input wire logic carry_in,
  output logic [7:0] result,
  output logic c_out,
  output logic ac_out,
  output logic ov_out,
  output logic arith
);
  logic [8:0] full;
  logic [4:0] nib;
  logic [7:0] low7;
  logic [7:0] bx;
  logic cin;
  logic sub;
  always_comb begin
    sub = (op == csf_pkg::CSF_OP_SUB) || (op == csf_pkg::CSF_OP_SBC);
    bx = sub ? ~b : b;
    // borrow-style subtract: no borrow means carry set
    cin = (op == csf_pkg::CSF_OP_SUB) ? 1'b1 :
          ((op == csf_pkg::CSF_OP_ADC) || (op == csf_pkg::CSF_OP_SBC)) ? carry_in : 1'b0;
    full = {1'b0, a} + {1'b0, bx} + {8'h00, cin};
    nib = {1'b0, a[3:0]} + {1'b0, bx[3:0]} + {4'h0, cin};
    low7 = {1'b0, a[6:0]} + {1'b0, bx[6:0]} + {7'h00, cin};
    arith = (op <= csf_pkg::CSF_OP_SBC);
    result = full[7:0];
    c_out = full[8];
    ac_out = nib[4];
    ov_out = low7[7] ^ full[8];
    unique case (op)
      csf_pkg::CSF_OP_AND: begin
        result = a & b;
      end
      csf_pkg::CSF_OP_XOR: begin
        result = a ^ b;
      end
      csf_pkg::CSF_OP_RLC: begin
        result = {a[6:0], carry_in};
        c_out = a[7];
      end
      csf_pkg::CSF_OP_RRC: begin
        result = {carry_in, a[7:1]};
        c_out = a[0];
      end
      default: begin
      end
    endcase
  end
endmodule

// ---- verilog/csf_core.sv ----
// status flags, bank pointer, pc low byte, table read and accumulator path behind apb
//
// Decided for this implementation: the APB interface to the registers and the address map.
`timescale 1ns/1ps
// Functional notes
// [RULE_01] bank pointer is two bits on large variant, one bit on small variant
// [RULE_02] jump or call takes target bank from the bank pointer
// [RULE_03] unused bank pointer bits read zero; used bits reset to zero
// [RULE_04] pc low byte write jumps within page and inserts one dummy cycle
// [RULE_05] table read puts high byte in table-high register, low byte chosen by user; here the low byte always goes to the accumulator
// [RULE_06] register-to-register moves always go through the accumulator
// [RULE_07] status writes never touch the watchdog and sleep flags; upper four read-only
// [RULE_08] watchdog flag bit 5 clears on reset, clear or halt; sets on timeout
// [RULE_09] sleep flag bit 4 clears on reset or clear; set by halt
// [RULE_10] bit 0 carry on add, no-borrow on subtract, also rotate-through-carry
// [RULE_11] bit 1 half carry out of low nibble, or no nibble borrow
// [RULE_12] bit 2 set when result is zero
// [RULE_13] bit 3 set when carry into msb differs from carry out
// [RULE_14] bit 7 equals signed-wrap xor result msb
// [RULE_15] plain subtract copies zero into chained-zero bit 6
// [RULE_16] borrow subtract ands chained-zero with current zero
// [RULE_17] other operations leave chained-zero alone
// [RULE_18] status is never pushed on calls or interrupts
// [RULE_19] extended direct address upper part selects the sector
// [RULE_20] first indirect port reaches sector 0 only; wide one any sector
// [RULE_21] indirect port reads zero at its own address; writes store nothing
// [RULE_22] arithmetic flags have no defined power-on value for software
module csf_core #(
  parameter int BANK_BITS = 2,
  parameter int SECT_BITS = 2
) (
  input wire logic CLK_SYS,
  input wire logic RST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic [15:0] TABLE_WORD,
  output logic [15:0] TABLE_ADDR,
  output logic [BANK_BITS-1:0] BRANCH_BANK,
  output logic [7:0] PC_LOW,
  output logic PC_LOAD,
  output logic PIPE_STALL,
  output logic [SECT_BITS+7:0] DATA_ADDR,
  output logic IND_ACTIVE
);
  typedef struct packed {
    logic [BANK_BITS-1:0] bank;
    logic [7:0] flags;
    logic [7:0] pc_low;
    logic pc_load;
    logic [1:0] stall;
    logic [7:0] tbl_low;
    logic [7:0] tbl_high;
    logic [7:0] tbl_hbyte;
    logic [7:0] acc;
    logic [7:0] dlow;
    logic [SECT_BITS-1:0] dsec;
    logic [7:0] ptr0;
    logic [7:0] wlow;
    logic [SECT_BITS-1:0] wsec;
    logic [SECT_BITS+7:0] daddr;
    logic ind;
    logic [BANK_BITS-1:0] br_bank;
    logic [31:0] rdata;
  } csf_state_t;

  csf_state_t st_r;
  csf_state_t st_nxt;
  logic [7:0] alu_res;
  logic alu_c;
  logic alu_ac;
  logic alu_ov;
  logic alu_arith;
  logic wr_acc;
  logic rd_acc;
  logic [7:0] wbyte;
  logic [2:0] op_sel;

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
    hit = (addr == off);
  endfunction

  assign wr_acc = PSEL && PENABLE && PWRITE;
  assign rd_acc = PSEL && PENABLE && !PWRITE;
  assign wbyte = PWDATA[7:0];
  assign op_sel = PWDATA[10:8];

  csf_alu i_csf_alu (
    .a(st_r.acc),
    .b(wbyte),
    .op(op_sel),
    .carry_in(st_r.flags[csf_pkg::BIT_C]),
    .result(alu_res),
    .c_out(alu_c),
    .ac_out(alu_ac),
    .ov_out(alu_ov),
    .arith(alu_arith)
  );

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    st_nxt = st_r;
    st_nxt.pc_load = 1'b0;
    // dummy count only runs once the load cycle is over, so the stall spans both
    if (st_r.stall != 2'h0 && !st_r.pc_load) begin
      st_nxt.stall = st_r.stall - 2'h1; // RULE_04
    end
    // the pc load pulse is one cycle; the pipe stall covers the refetch
    if (wr_acc && hit(PADDR, csf_pkg::OFF_BANK)) begin
      st_nxt.bank = wbyte[BANK_BITS-1:0]; // RULE_01
    end
    if (wr_acc && hit(PADDR, csf_pkg::OFF_FLAGS)) begin
      st_nxt.flags[3:0] = wbyte[3:0] & csf_pkg::FLAGS_SW_MASK; // RULE_07
    end
    if (wr_acc && hit(PADDR, csf_pkg::OFF_PCLOW)) begin
      st_nxt.pc_low = wbyte; // RULE_04
      st_nxt.pc_load = 1'b1;
      st_nxt.stall = 2'(csf_pkg::PCLOW_DUMMY_CYC); // RULE_04
    end
    if (wr_acc && hit(PADDR, csf_pkg::OFF_TBL_LOW)) begin
      st_nxt.tbl_low = wbyte;
    end
    if (wr_acc && hit(PADDR, csf_pkg::OFF_TBL_HIGH)) begin
      st_nxt.tbl_high = wbyte;
    end
    // accumulator is the only landing place for moves and results
    if (wr_acc && hit(PADDR, csf_pkg::OFF_ACC)) begin
      st_nxt.acc = wbyte; // RULE_06
    end
    // pointer writes take the accumulator, never bus data
    if (wr_acc && hit(PADDR, csf_pkg::OFF_PTR0)) begin
      st_nxt.ptr0 = st_r.acc; // RULE_06
    end
    if (wr_acc && hit(PADDR, csf_pkg::OFF_WPTR_LOW)) begin
      st_nxt.wlow = st_r.acc; // RULE_06
    end
    if (wr_acc && hit(PADDR, csf_pkg::OFF_WPTR_SEC)) begin
      st_nxt.wsec = st_r.acc[SECT_BITS-1:0]; // RULE_06
    end
    if (wr_acc && hit(PADDR, csf_pkg::OFF_DADDR)) begin
      st_nxt.daddr = {wbyte[SECT_BITS+7-8:0] & {SECT_BITS{1'b1}}, st_r.acc}; // RULE_19
    end
    if (wr_acc && (hit(PADDR, csf_pkg::OFF_IND0) || hit(PADDR, csf_pkg::OFF_IND1))) begin
      st_nxt.ind = 1'b1;
      st_nxt.daddr = hit(PADDR, csf_pkg::OFF_IND0) ? {{SECT_BITS{1'b0}}, st_r.ptr0} // RULE_20
                                                   : {st_r.wsec, st_r.wlow}; // RULE_20
    end else if (wr_acc) begin
      st_nxt.ind = 1'b0;
    end
    if (wr_acc && hit(PADDR, csf_pkg::OFF_OP)) begin
      st_nxt.acc = alu_res;
      st_nxt.flags[csf_pkg::BIT_Z] = (alu_res == 8'h00); // RULE_12
      if (alu_arith || op_sel == csf_pkg::CSF_OP_RLC || op_sel == csf_pkg::CSF_OP_RRC) begin
        st_nxt.flags[csf_pkg::BIT_C] = alu_c; // RULE_10
      end
      if (alu_arith) begin
        st_nxt.flags[csf_pkg::BIT_AC] = alu_ac; // RULE_11
        st_nxt.flags[csf_pkg::BIT_OV] = alu_ov; // RULE_13
        st_nxt.flags[csf_pkg::BIT_SC] = alu_ov ^ alu_res[7]; // RULE_14
      end
      if (op_sel == csf_pkg::CSF_OP_SUB) begin
        st_nxt.flags[csf_pkg::BIT_CZ] = (alu_res == 8'h00); // RULE_15
      end else if (op_sel == csf_pkg::CSF_OP_SBC) begin
        st_nxt.flags[csf_pkg::BIT_CZ] = st_r.flags[csf_pkg::BIT_CZ] && (alu_res == 8'h00); // RULE_16
      end
      // RULE_17: any other operation keeps chained-zero as it was
    end
    if (wr_acc && hit(PADDR, csf_pkg::OFF_SYS)) begin
      // halt clears the watchdog flag; a timeout in the same write wins
      if (wbyte[csf_pkg::SYS_WATCHDOG_CLEAR_INSTRUCTION]) begin
        st_nxt.flags[csf_pkg::BIT_PDF] = 1'b0; // RULE_09
        st_nxt.flags[csf_pkg::BIT_TO] = 1'b0; // RULE_08
      end
      if (wbyte[csf_pkg::SYS_HALT]) begin
        st_nxt.flags[csf_pkg::BIT_PDF] = 1'b1; // RULE_09
        st_nxt.flags[csf_pkg::BIT_TO] = 1'b0; // RULE_08
      end
      if (wbyte[csf_pkg::SYS_WDT_TIMEOUT]) begin
        st_nxt.flags[csf_pkg::BIT_TO] = 1'b1; // RULE_08
      end
      if (wbyte[csf_pkg::SYS_TBL_READ]) begin
        st_nxt.tbl_hbyte = TABLE_WORD[15:8]; // RULE_05
        st_nxt.acc = TABLE_WORD[7:0]; // RULE_05
      end
      if (wbyte[csf_pkg::SYS_JUMP]) begin
        st_nxt.br_bank = st_r.bank; // RULE_02
      end
    end
    // status is only a register; nothing here saves it on calls (RULE_18 by omission)
    st_nxt.rdata = 32'h0000_0000;
    if (rd_acc) begin
      unique case (PADDR)
        csf_pkg::OFF_BANK: st_nxt.rdata = 32'(st_r.bank); // RULE_03
        csf_pkg::OFF_FLAGS: st_nxt.rdata = {24'h000000, st_r.flags};
        csf_pkg::OFF_PCLOW: st_nxt.rdata = {24'h000000, st_r.pc_low};
        csf_pkg::OFF_TBL_LOW: st_nxt.rdata = {24'h000000, st_r.tbl_low};
        csf_pkg::OFF_TBL_HIGH: st_nxt.rdata = {24'h000000, st_r.tbl_high};
        csf_pkg::OFF_TBL_HBYTE: st_nxt.rdata = {24'h000000, st_r.tbl_hbyte};
        csf_pkg::OFF_ACC: st_nxt.rdata = {24'h000000, st_r.acc};
        csf_pkg::OFF_PTR0: st_nxt.rdata = {24'h000000, st_r.ptr0};
        csf_pkg::OFF_WPTR_LOW: st_nxt.rdata = {24'h000000, st_r.wlow};
        csf_pkg::OFF_WPTR_SEC: st_nxt.rdata = 32'(st_r.wsec);
        csf_pkg::OFF_DADDR: st_nxt.rdata = 32'(st_r.daddr);
        default: st_nxt.rdata = 32'h0000_0000; // RULE_21
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // flags reset to zero for determinism; software must not rely on it
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      st_r <= '0;
      st_r.bank <= csf_pkg::BANK_RST[BANK_BITS-1:0]; // RULE_03
      st_r.flags <= csf_pkg::FLAGS_RST; // RULE_22
    end else begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // one-cycle answer: read data is decoded combinationally in the access phase
  assign PREADY = PSEL && PENABLE;
  assign PSLVERR = 1'b0;
  assign PRDATA = st_nxt.rdata;
  assign TABLE_ADDR = {st_r.tbl_high, st_r.tbl_low}; // RULE_05
  assign BRANCH_BANK = st_r.br_bank; // RULE_02
  assign PC_LOW = st_r.pc_low;
  assign PC_LOAD = st_r.pc_load;
  assign PIPE_STALL = st_r.pc_load || (st_r.stall != 2'h0);
  assign DATA_ADDR = st_r.daddr;
  assign IND_ACTIVE = st_r.ind;

  ////////////////////////////////////////////////////////////////////////////
  property p_rst_bank;
    @(posedge CLK_SYS) $rose(RST_N) |-> st_r.bank == '0;
  endproperty
  a_rst_bank: assert property (p_rst_bank) else $error("bank not zero after reset"); // RULE_03

  property p_flags_ro;
    @(posedge CLK_SYS) disable iff (!RST_N)
      wr_acc && hit(PADDR, csf_pkg::OFF_FLAGS) |=> st_r.flags[7:4] == $past(st_r.flags[7:4]);
  endproperty
  a_flags_ro: assert property (p_flags_ro) else $error("upper flags written"); // RULE_07

  property p_to_set;
    @(posedge CLK_SYS) disable iff (!RST_N)
      wr_acc && hit(PADDR, csf_pkg::OFF_SYS) && wbyte[csf_pkg::SYS_WDT_TIMEOUT]
      |=> st_r.flags[csf_pkg::BIT_TO];
  endproperty
  a_to_set: assert property (p_to_set) else $error("timeout flag not set"); // RULE_08

  property p_halt;
    @(posedge CLK_SYS) disable iff (!RST_N)
      wr_acc && hit(PADDR, csf_pkg::OFF_SYS) && wbyte[csf_pkg::SYS_HALT]
      |=> st_r.flags[csf_pkg::BIT_PDF];
  endproperty
  a_halt: assert property (p_halt) else $error("sleep flag not set by halt"); // RULE_09

  property p_sc;
    @(posedge CLK_SYS) disable iff (!RST_N)
      wr_acc && hit(PADDR, csf_pkg::OFF_OP) && alu_arith
      |=> st_r.flags[csf_pkg::BIT_SC] == (st_r.flags[csf_pkg::BIT_OV] ^ st_r.acc[7]);
  endproperty
  a_sc: assert property (p_sc) else $error("sign check mismatch"); // RULE_14

  property p_zero;
    @(posedge CLK_SYS) disable iff (!RST_N)
      wr_acc && hit(PADDR, csf_pkg::OFF_OP) |=> st_r.flags[csf_pkg::BIT_Z] == (st_r.acc == 8'h00);
  endproperty
  a_zero: assert property (p_zero) else $error("zero flag mismatch"); // RULE_12

  property p_cz_sub;
    @(posedge CLK_SYS) disable iff (!RST_N)
      wr_acc && hit(PADDR, csf_pkg::OFF_OP) && op_sel == csf_pkg::CSF_OP_SUB
      |=> st_r.flags[csf_pkg::BIT_CZ] == st_r.flags[csf_pkg::BIT_Z];
  endproperty
  a_cz_sub: assert property (p_cz_sub) else $error("chained zero not copied"); // RULE_15

  property p_cz_keep;
    @(posedge CLK_SYS) disable iff (!RST_N)
      wr_acc && hit(PADDR, csf_pkg::OFF_OP) && op_sel != csf_pkg::CSF_OP_SUB
      && op_sel != csf_pkg::CSF_OP_SBC |=> $stable(st_r.flags[csf_pkg::BIT_CZ]);
  endproperty
  a_cz_keep: assert property (p_cz_keep) else $error("chained zero changed"); // RULE_17

  property p_pcl;
    @(posedge CLK_SYS) disable iff (!RST_N)
      wr_acc && hit(PADDR, csf_pkg::OFF_PCLOW) |=> PC_LOAD ##1 (PIPE_STALL && !PC_LOAD) ##1 !PIPE_STALL;
  endproperty
  a_pcl: assert property (p_pcl) else $error("pc low dummy cycle wrong"); // RULE_04

  property p_ind0;
    @(posedge CLK_SYS) disable iff (!RST_N)
      wr_acc && hit(PADDR, csf_pkg::OFF_IND0) |=> DATA_ADDR[SECT_BITS+7:8] == '0;
  endproperty
  a_ind0: assert property (p_ind0) else $error("sector 0 port left sector 0"); // RULE_20

  // unsigned wrap of the sum shows the carry without reusing the adder
  property p_add_c;
    @(posedge CLK_SYS) disable iff (!RST_N)
      wr_acc && hit(PADDR, csf_pkg::OFF_OP) && op_sel == csf_pkg::CSF_OP_ADD
      |=> st_r.flags[csf_pkg::BIT_C] == (st_r.acc < $past(st_r.acc));
  endproperty
  a_add_c: assert property (p_add_c) else $error("carry wrong after add"); // RULE_10

  property p_add_ac;
    @(posedge CLK_SYS) disable iff (!RST_N)
      wr_acc && hit(PADDR, csf_pkg::OFF_OP) && op_sel == csf_pkg::CSF_OP_ADD
      |=> st_r.flags[csf_pkg::BIT_AC] == (st_r.acc[3:0] < $past(st_r.acc[3:0]));
  endproperty
  a_add_ac: assert property (p_add_ac) else $error("half carry wrong after add"); // RULE_11

  property p_add_ov;
    @(posedge CLK_SYS) disable iff (!RST_N)
      wr_acc && hit(PADDR, csf_pkg::OFF_OP) && op_sel == csf_pkg::CSF_OP_ADD
      |=> st_r.flags[csf_pkg::BIT_OV] == (($past(st_r.acc[7]) == $past(wbyte[7]))
      && (st_r.acc[7] != $past(st_r.acc[7])));
  endproperty
  a_add_ov: assert property (p_add_ov) else $error("signed wrap wrong after add"); // RULE_13

  property p_cz_sbc;
    @(posedge CLK_SYS) disable iff (!RST_N)
      wr_acc && hit(PADDR, csf_pkg::OFF_OP) && op_sel == csf_pkg::CSF_OP_SBC
      |=> st_r.flags[csf_pkg::BIT_CZ] == ($past(st_r.flags[csf_pkg::BIT_CZ])
      && st_r.flags[csf_pkg::BIT_Z]);
  endproperty
  a_cz_sbc: assert property (p_cz_sbc) else $error("chained zero not anded"); // RULE_16

  property p_flags_rw;
    @(posedge CLK_SYS) disable iff (!RST_N)
      wr_acc && hit(PADDR, csf_pkg::OFF_FLAGS) |=> st_r.flags[3:0] == $past(wbyte[3:0]);
  endproperty
  a_flags_rw: assert property (p_flags_rw) else $error("lower flags not written"); // RULE_07

  property p_jump;
    @(posedge CLK_SYS) disable iff (!RST_N)
      wr_acc && hit(PADDR, csf_pkg::OFF_SYS) && wbyte[csf_pkg::SYS_JUMP]
      |=> BRANCH_BANK == $past(st_r.bank);
  endproperty
  a_jump: assert property (p_jump) else $error("branch bank not taken"); // RULE_02

  property p_tbl;
    @(posedge CLK_SYS) disable iff (!RST_N)
      wr_acc && hit(PADDR, csf_pkg::OFF_SYS) && wbyte[csf_pkg::SYS_TBL_READ]
      |=> st_r.tbl_hbyte == $past(TABLE_WORD[15:8]) && st_r.acc == $past(TABLE_WORD[7:0]);
  endproperty
  a_tbl: assert property (p_tbl) else $error("table read bytes misplaced"); // RULE_05

  property p_ind_rd;
    @(posedge CLK_SYS) disable iff (!RST_N)
      rd_acc && (hit(PADDR, csf_pkg::OFF_IND0) || hit(PADDR, csf_pkg::OFF_IND1))
      |-> PRDATA == 32'h0000_0000;
  endproperty
  a_ind_rd: assert property (p_ind_rd) else $error("indirect port read not zero"); // RULE_21

  c_sbc: cover property (@(posedge CLK_SYS) wr_acc && hit(PADDR, csf_pkg::OFF_OP)
    && op_sel == csf_pkg::CSF_OP_SBC);
  c_tbl: cover property (@(posedge CLK_SYS) wr_acc && hit(PADDR, csf_pkg::OFF_SYS)
    && wbyte[csf_pkg::SYS_TBL_READ]);
  c_jump: cover property (@(posedge CLK_SYS) wr_acc && hit(PADDR, csf_pkg::OFF_SYS)
    && wbyte[csf_pkg::SYS_JUMP] && st_r.bank != '0);
endmodule

// ---- verilog/csf_pkg.sv ----
// package: register map, field positions, reset values and operation codes of the status block
package csf_pkg;
  localparam logic [7:0] ADDR_W = 8'h0C;
  localparam logic [7:0] OFF_BANK = 8'h00;
  localparam logic [7:0] OFF_FLAGS = 8'h04;
  localparam logic [7:0] OFF_PCLOW = 8'h08;
  localparam logic [7:0] OFF_TBL_LOW = 8'h0C;
  localparam logic [7:0] OFF_TBL_HIGH = 8'h10;
  localparam logic [7:0] OFF_TBL_HBYTE = 8'h14;
  localparam logic [7:0] OFF_ACC = 8'h18;
  localparam logic [7:0] OFF_OP = 8'h1C;
  localparam logic [7:0] OFF_SYS = 8'h20;
  localparam logic [7:0] OFF_DADDR = 8'h24;
  localparam logic [7:0] OFF_PTR0 = 8'h28;
  localparam logic [7:0] OFF_WPTR_LOW = 8'h2C;
  localparam logic [7:0] OFF_WPTR_SEC = 8'h30;
  localparam logic [7:0] OFF_IND0 = 8'h34;
  localparam logic [7:0] OFF_IND1 = 8'h38;
  localparam logic [7:0] OFF_XFER = 8'h3C;
  localparam int BIT_C = 0;
  localparam int BIT_AC = 1;
  localparam int BIT_Z = 2;
  localparam int BIT_OV = 3;
  localparam int BIT_PDF = 4;
  localparam int BIT_TO = 5;
  localparam int BIT_CZ = 6;
  localparam int BIT_SC = 7;
  localparam logic [7:0] BANK_RST = 8'h00;
  localparam logic [7:0] FLAGS_RST = 8'h00;
  localparam logic [3:0] FLAGS_SW_MASK = 4'hF;
  localparam int PCLOW_DUMMY_CYC = 1;
  localparam int SYS_WDT_TIMEOUT = 0;
  localparam int SYS_WATCHDOG_CLEAR_INSTRUCTION = 1;
  localparam int SYS_HALT = 2;
  localparam int SYS_TBL_READ = 3;
  localparam int SYS_JUMP = 4;
  typedef enum logic [2:0] {
    CSF_OP_ADD = 3'h0,
    CSF_OP_ADC = 3'h1,
    CSF_OP_SUB = 3'h2,
    CSF_OP_SBC = 3'h3,
    CSF_OP_AND = 3'h4,
    CSF_OP_RLC = 3'h5,
    CSF_OP_RRC = 3'h6,
    CSF_OP_XOR = 3'h7
  } csf_op_t;
endpackage
